// >>> bench/ctl_model.sv
`timescale 1ns/100ps
`include "hw_status_consts.svh"
module ctl_model
    import hw_status_pkg::*;
(
    // Clock
    input  wire logic  clk,
    // Commands
    output logic       cmd_wr,
    output logic       cmd_rd,
    output sel_t       cmd_sel,
    output word_t      cmd_wdata,
    output logic       cls,
    // Answers
    input  wire word_t rdata_ff,
    input  wire logic  rvalid_ff
);
    initial begin
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_sel   = 3'h7;
        cmd_wdata = 16'h0000;
        cls       = 1'b0;
    end
    // Data is inverted after use so a stale word never looks valid
    task automatic wr(input sel_t s, input word_t d);
        @(negedge clk);
        cmd_wr    = 1'b1;
        cmd_sel   = s;
        cmd_wdata = d;
        @(negedge clk);
        cmd_wr    = 1'b0;
        cmd_wdata = ~d;
    endtask : wr
    task automatic rd(input sel_t s, output word_t d, output logic v);
        @(negedge clk);
        cmd_rd  = 1'b1;
        cmd_sel = s;
        @(negedge clk);
        cmd_rd  = 1'b0;
        d       = rdata_ff;
        v       = rvalid_ff;
    endtask : rd
    task automatic clear_status();
        @(negedge clk);
        cls = 1'b1;
        @(negedge clk);
        cls = 1'b0;
    endtask : clear_status
    task automatic disable_all();
        wr(`SEL_ENABLE, 16'h0000);
    endtask : disable_all
endmodule : ctl_model

// >>> bench/hw_status_group_one_tb.sv
`timescale 1ns/100ps
`include "hw_status_consts.svh"
module hw_status_group_one_tb
    import hw_status_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [16:0] stim = 17'h0;
    logic        cmd_wr, cmd_rd, cls, rvalid_ff, summary_ff;
    sel_t        cmd_sel;
    word_t       cmd_wdata, rdata_ff, d;
    logic        v;
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [16:0] extra [6] = '{17'h03000, 17'h05000, 17'h07000,
                               17'h0a000, 17'h0d000, 17'h1ffff};
    always #12.5 clk = ~clk;
    hw_status_group_one dut (.clk(clk), .rst_b(rst_b),
        .batt_low(stim[0]), .mike_keyed(stim[1]), .overpower(stim[2]),
        .self_test_fail(stim[3]), .limit_high(stim[4]),
        .limit_low(stim[5]), .ric_int1(stim[6]), .ric_int2(stim[7]),
        .dec_armed(stim[8]), .dec_measuring(stim[9]),
        .dec_level_low(stim[10]), .dec_results(stim[11]),
        .enc_two_field(stim[12]), .enc_send_a(stim[13]),
        .enc_send_b(stim[14]), .enc_func_gen(stim[15]),
        .comm_summary(stim[16]), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cls(cls),
        .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
        .summary_ff(summary_ff));
    ctl_model ctl (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cls(cls),
        .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff));
    function automatic word_t cond_of(input logic [16:0] s);
        word_t c;
        c       = 16'h0000;
        c[1:0]  = s[1:0];
        c[4:3]  = s[3:2];
        c[5]    = s[4] | s[5];
        c[6]    = s[16];
        c[7]    = (~s[12] & s[13] | s[12] & (s[13] ^ s[14]))
                  & ~s[15];
        c[8]    = s[12] & s[13] & s[14];
        c[12:9] = s[11:8];
        c[14:13] = s[7:6];
        return c;
    endfunction : cond_of
    task automatic print_verdict();
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic cmp(input string n, input word_t e, input word_t g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic chk(input sel_t s, input word_t e);
        ctl.rd(s, d, v);
        cmp("rvalid", 16'h0001, {15'h0, v});
        cmp($sformatf("read sel %0d", s), e, d);
    endtask : chk
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask : settle
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        chk(`SEL_PTR, `PTR_RESET);
        chk(`SEL_NTR, `NTR_RESET);
        chk(`SEL_ENABLE, `ENABLE_RESET);
        chk(3'h5, 16'h0000);
        for (int i = 0; i < 23; i++) begin
            stim = (i < 17) ? (17'h1 << i) : extra[i - 17];
            settle();
            chk(`SEL_COND, cond_of(stim));
        end
        ctl.wr(`SEL_COND, 16'h0000);
        chk(`SEL_COND, cond_of(stim));
        stim = 17'h0;
        settle();
        ctl.rd(`SEL_EVENT, d, v);
        ctl.wr(`SEL_PTR, 16'h0002);
        ctl.wr(`SEL_NTR, 16'h0001);
        stim = 17'h3;
        settle();
        cmp("summary", 16'h0, {15'h0, summary_ff});
        ctl.wr(`SEL_ENABLE, 16'h0002);
        settle();
        cmp("summary", 16'h1, {15'h0, summary_ff});
        chk(`SEL_EVENT, 16'h0002);
        chk(`SEL_EVENT, 16'h0000);
        settle();
        cmp("summary", 16'h0, {15'h0, summary_ff});
        stim = 17'h0;
        settle();
        ctl.wr(`SEL_ENABLE, 16'h0001);
        settle();
        cmp("summary", 16'h1, {15'h0, summary_ff});
        ctl.disable_all();
        settle();
        cmp("summary", 16'h0, {15'h0, summary_ff});
        ctl.clear_status();
        chk(`SEL_EVENT, 16'h0000);
        print_verdict();
    end
endmodule : hw_status_group_one_tb

// >>> hw/edge_filter.sv
`timescale 1ns/100ps
module edge_filter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Condition now and before
    input  wire logic cond_now,
    input  wire logic cond_prev,
    // Filters
    input  wire logic pos_en,
    input  wire logic neg_en,
    // Event control
    input  wire logic clr,
    output logic      event_ff
);
    wire rise_hit = cond_now & ~cond_prev & pos_en;
    wire fall_hit = ~cond_now & cond_prev & neg_en;
    wire hit      = rise_hit | fall_hit;
    // A new edge wins over a clear in the same cycle
    wire nxt_event = hit | (event_ff & ~clr);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            event_ff <= 1'b0;
        end else begin
            event_ff <= nxt_event;
        end
    end
endmodule : edge_filter

// >>> hw/hw_status_group_one.sv
`timescale 1ns/100ps
`include "hw_status_consts.svh"
module hw_status_group_one
    import hw_status_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_b,
    // Hardware condition pins
    input  wire logic  batt_low,
    input  wire logic  mike_keyed,
    input  wire logic  overpower,
    input  wire logic  self_test_fail,
    input  wire logic  limit_high,
    input  wire logic  limit_low,
    input  wire logic  ric_int1,
    input  wire logic  ric_int2,
    // Signalling decoder and encoder
    input  wire logic  dec_armed,
    input  wire logic  dec_measuring,
    input  wire logic  dec_level_low,
    input  wire logic  dec_results,
    input  wire logic  enc_two_field,
    input  wire logic  enc_send_a,
    input  wire logic  enc_send_b,
    input  wire logic  enc_func_gen,
    // Communicate group summary, same clock
    input  wire logic  comm_summary,
    // Status command port
    input  wire logic  cmd_wr,
    input  wire logic  cmd_rd,
    input  wire sel_t  cmd_sel,
    input  wire word_t cmd_wdata,
    input  wire logic  cls,
    output word_t      rdata_ff,
    output logic       rvalid_ff,
    // Summary to status byte
    output logic       summary_ff
);
    // Pins are asynchronous; two stages before any decoding
    word_t pin_raw;
    word_t sync1_ff;
    word_t sync2_ff;
    word_t nxt_cond;
    word_t cond_ff;
    word_t ptr_ff;
    word_t ntr_ff;
    word_t enable_ff;
    word_t event_bits;
    always_comb begin
        pin_raw[`PIN_BATT_LOW]   = batt_low;
        pin_raw[`PIN_MIKE_KEYED] = mike_keyed;
        pin_raw[`PIN_OVERPOWER]  = overpower;
        pin_raw[`PIN_SELF_TEST]  = self_test_fail;
        pin_raw[`PIN_LIMIT_HIGH] = limit_high;
        pin_raw[`PIN_LIMIT_LOW]  = limit_low;
        pin_raw[`PIN_RIC_INT1]   = ric_int1;
        pin_raw[`PIN_RIC_INT2]   = ric_int2;
        pin_raw[`PIN_ARMED]      = dec_armed;
        pin_raw[`PIN_MEASURING]  = dec_measuring;
        pin_raw[`PIN_LEVEL_LOW]  = dec_level_low;
        pin_raw[`PIN_RESULTS]    = dec_results;
        pin_raw[`PIN_TWO_FIELD]  = enc_two_field;
        pin_raw[`PIN_SEND_A]     = enc_send_a;
        pin_raw[`PIN_SEND_B]     = enc_send_b;
        pin_raw[`PIN_FUNC_GEN]   = enc_func_gen;
    end
    // Decoding after the synchroniser keeps pin skew from glitching bits
    wire two_field   = sync2_ff[`PIN_TWO_FIELD];
    wire send_a      = sync2_ff[`PIN_SEND_A];
    wire send_b      = sync2_ff[`PIN_SEND_B];
    wire func_gen    = sync2_ff[`PIN_FUNC_GEN];
    wire single_sent = ~two_field & send_a;
    wire one_of_two  = two_field & (send_a ^ send_b);
    wire both_sent   = two_field & send_a & send_b;
    always_comb begin
        nxt_cond = 16'h0000;
        nxt_cond[`BIT_BATT_LOW]   = sync2_ff[`PIN_BATT_LOW];
        nxt_cond[`BIT_MIKE_KEYED] = sync2_ff[`PIN_MIKE_KEYED];
        nxt_cond[`BIT_OVERPOWER]  = sync2_ff[`PIN_OVERPOWER];
        nxt_cond[`BIT_SELF_TEST]  = sync2_ff[`PIN_SELF_TEST];
        nxt_cond[`BIT_LIMIT]      = sync2_ff[`PIN_LIMIT_HIGH]
                                    | sync2_ff[`PIN_LIMIT_LOW];
        // Comm summary is already synchronous; it skips the synchroniser
        nxt_cond[`BIT_COMM_SUM]   = comm_summary;
        nxt_cond[`BIT_SEND_INFO]  = (single_sent | one_of_two)
                                    & ~func_gen;
        nxt_cond[`BIT_SEND_AUX]   = both_sent;
        nxt_cond[`BIT_ARMED]      = sync2_ff[`PIN_ARMED];
        nxt_cond[`BIT_MEASURING]  = sync2_ff[`PIN_MEASURING];
        nxt_cond[`BIT_LEVEL_LOW]  = sync2_ff[`PIN_LEVEL_LOW];
        nxt_cond[`BIT_RESULTS]    = sync2_ff[`PIN_RESULTS];
        nxt_cond[`BIT_RIC_INT1]   = sync2_ff[`PIN_RIC_INT1];
        nxt_cond[`BIT_RIC_INT2]   = sync2_ff[`PIN_RIC_INT2];
    end
    wire rd_event = cmd_rd & (cmd_sel == `SEL_EVENT);
    wire evt_clr  = rd_event | cls;
    wire wr_ptr   = cmd_wr & (cmd_sel == `SEL_PTR);
    wire wr_ntr   = cmd_wr & (cmd_sel == `SEL_NTR);
    wire wr_en    = cmd_wr & (cmd_sel == `SEL_ENABLE);
    word_t rd_mux;
    always_comb begin
        unique case (cmd_sel)
            `SEL_COND:   rd_mux = cond_ff;
            `SEL_PTR:    rd_mux = ptr_ff;
            `SEL_NTR:    rd_mux = ntr_ff;
            `SEL_EVENT:  rd_mux = event_bits;
            `SEL_ENABLE: rd_mux = enable_ff;
            default:     rd_mux = 16'h0000;
        endcase
    end
    wire nxt_summary = |(event_bits & enable_ff);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cond_ff   <= 16'h0000;
            ptr_ff    <= `PTR_RESET;
            ntr_ff    <= `NTR_RESET;
            enable_ff <= `ENABLE_RESET;
        end else begin
            cond_ff <= nxt_cond;
            if (wr_ptr) begin
                ptr_ff <= cmd_wdata;
            end
            if (wr_ntr) begin
                ntr_ff <= cmd_wdata;
            end
            // Writing zero keeps every event out of the summary; events still latch
            if (wr_en) begin
                enable_ff <= cmd_wdata;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_ff   <= 16'h0000;
            rvalid_ff  <= 1'b0;
            summary_ff <= 1'b0;
        end else begin
            rvalid_ff  <= cmd_rd;
            rdata_ff   <= cmd_rd ? rd_mux : rdata_ff;
            summary_ff <= nxt_summary;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < `REG_W; gi++) begin : g_evt
            edge_filter u_filt (
                .clk       (clk),
                .rst_b     (rst_b),
                .cond_now  (nxt_cond[gi]),
                .cond_prev (cond_ff[gi]),
                .pos_en    (ptr_ff[gi]),
                .neg_en    (ntr_ff[gi]),
                .clr       (evt_clr),
                .event_ff  (event_bits[gi])
            );
        end
    endgenerate
    AST_BIT15_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        cond_ff[`BIT_ALWAYS0] == 1'b0 && cond_ff[`BIT_UNUSED2] == 1'b0)
        else $error("Unused condition bit set");
    AST_FUNC_GEN: assert property (@(posedge clk) disable iff (!rst_b)
        func_gen |=> !cond_ff[`BIT_SEND_INFO])
        else $error("Info bit set in function generator mode");
    AST_READ_CLR: assert property (@(posedge clk) disable iff (!rst_b)
        (rd_event && nxt_cond == cond_ff) |=> event_bits == 16'h0000)
        else $error("Event not cleared on read");
    AST_CLS_CLR: assert property (@(posedge clk) disable iff (!rst_b)
        (cls && nxt_cond == cond_ff) |=> event_bits == 16'h0000)
        else $error("Event not cleared on clear-status");
    AST_RISE_LATCH: assert property (@(posedge clk) disable iff (!rst_b)
        |(nxt_cond & ~cond_ff & ptr_ff) |=> |event_bits)
        else $error("Rising edge not latched");
    AST_FALL_LATCH: assert property (@(posedge clk) disable iff (!rst_b)
        |(~nxt_cond & cond_ff & ntr_ff) |=> |event_bits)
        else $error("Falling edge not latched");
    AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 summary_ff == |($past(event_bits) & $past(enable_ff)))
        else $error("Summary mismatch");
    AST_ENABLE_WR: assert property (@(posedge clk) disable iff (!rst_b)
        wr_en |=> enable_ff == $past(cmd_wdata))
        else $error("Enable write lost");
    AST_COMM_BIT: assert property (@(posedge clk) disable iff (!rst_b)
        comm_summary |=> cond_ff[`BIT_COMM_SUM])
        else $error("Comm summary not reflected");
endmodule : hw_status_group_one

// >>> pkg/hw_status_consts.svh
`ifndef HW_STATUS_CONSTS_SVH
`define HW_STATUS_CONSTS_SVH
`define REG_W          16
`define SEL_COND       3'h0
`define SEL_PTR        3'h1
`define SEL_NTR        3'h2
`define SEL_EVENT      3'h3
`define SEL_ENABLE     3'h4
`define PTR_RESET      16'h7fff
`define NTR_RESET      16'h0000
`define ENABLE_RESET   16'h0000
`define BIT_BATT_LOW   0
`define BIT_MIKE_KEYED 1
`define BIT_UNUSED2    2
`define BIT_OVERPOWER  3
`define BIT_SELF_TEST  4
`define BIT_LIMIT      5
`define BIT_COMM_SUM   6
`define BIT_SEND_INFO  7
`define BIT_SEND_AUX   8
`define BIT_ARMED      9
`define BIT_MEASURING  10
`define BIT_LEVEL_LOW  11
`define BIT_RESULTS    12
`define BIT_RIC_INT1   13
`define BIT_RIC_INT2   14
`define BIT_ALWAYS0    15
`define PIN_BATT_LOW   0
`define PIN_MIKE_KEYED 1
`define PIN_OVERPOWER  2
`define PIN_SELF_TEST  3
`define PIN_LIMIT_HIGH 4
`define PIN_LIMIT_LOW  5
`define PIN_RIC_INT1   6
`define PIN_RIC_INT2   7
`define PIN_ARMED      8
`define PIN_MEASURING  9
`define PIN_LEVEL_LOW  10
`define PIN_RESULTS    11
`define PIN_TWO_FIELD  12
`define PIN_SEND_A     13
`define PIN_SEND_B     14
`define PIN_FUNC_GEN   15
`endif

// >>> pkg/hw_status_pkg.sv
package hw_status_pkg;
    typedef logic [15:0] word_t;
    typedef logic [2:0]  sel_t;
endpackage : hw_status_pkg
